//--- hdl/uart_efc_pkg.sv
// constants for the enhanced feature control block of one uart channel
package uart_efc_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] OFS_MODEM_STATUS_LOCATION = 8'h00;
    localparam logic [7:0] OFS_SCRATCH_STORE = 8'h04;
    localparam logic [7:0] OFS_FEATURE_CONTROL = 8'h08;
    localparam logic [7:0] OFS_ENHANCED_FEATURE = 8'h0C;
    localparam logic [7:0] OFS_CONFIG = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // reset values
    localparam logic [7:0] RST_SCRATCH_STORE = 8'hFF;
    localparam logic [7:0] RST_FEATURE_CONTROL = 8'h00;
    localparam logic [7:0] RST_ENHANCED_FEATURE = 8'h00;
    localparam logic [3:0] RST_TURNAROUND = 4'h0;
    localparam logic [15:0] RST_BAUD_DIV = 16'h0001;
    // field positions
    localparam int FC_IR_INV_BIT = 4;
    localparam int FC_RS485_BIT = 5;
    localparam int FC_TABLE_LSB = 6;
    localparam int EF_ENABLE_BIT = 4;
    localparam int TURN_LSB = 4;
    // trigger table code for table d
    localparam logic [1:0] TABLE_D = 2'h3;
    // software flow control pair codes
    localparam logic [1:0] SWFC_NONE = 2'h0;
    localparam logic [1:0] SWFC_SECOND = 2'h1;
    localparam logic [1:0] SWFC_FIRST = 2'h2;
    localparam logic [1:0] SWFC_BOTH = 2'h3;
    // oversampling: one bit period is 16 baud ticks
    localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hF;
    localparam logic [3:0] FRAME_BITS = 4'hA;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_SEND = 4'b0010,
        TX_TURN = 4'b0100,
        TX_HOLD = 4'b1000
    } tx_state_t;
endpackage

//--- hdl/uart_efc.sv
// enhanced feature control of one uart channel with axi4-lite registers
module uart_efc
    import uart_efc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_load_i,
    input wire logic tx_fifo_empty_i,
    input wire logic ir_rx_i,
    output logic ir_rx_o,
    output logic rs485_dir_o,
    output logic tx_line_busy_o,
    output logic tx_int_o,
    output logic [1:0] trigger_table_o,
    output logic [5:0] flow_hysteresis_o,
    output logic flow_adjacent_level_o,
    output logic [1:0] swfc_tx_mode_o,
    output logic [1:0] swfc_rx_mode_o,
    output logic swfc_rx_either_o,
    output logic swfc_rx_sequence_o
);
    function automatic logic [5:0] hyst_chars(input logic [3:0] code);
        unique case (code)
            4'h0: hyst_chars = 6'd0;
            4'h1: hyst_chars = 6'd4;
            4'h2: hyst_chars = 6'd6;
            4'h3: hyst_chars = 6'd8;
            4'h4: hyst_chars = 6'd8;
            4'h5: hyst_chars = 6'd16;
            4'h6: hyst_chars = 6'd24;
            4'h7: hyst_chars = 6'd32;
            4'h8: hyst_chars = 6'd40;
            4'h9: hyst_chars = 6'd44;
            4'hA: hyst_chars = 6'd48;
            4'hB: hyst_chars = 6'd52;
            4'hC: hyst_chars = 6'd12;
            4'hD: hyst_chars = 6'd20;
            4'hE: hyst_chars = 6'd28;
            default: hyst_chars = 6'd36;
        endcase
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                              input logic [3:0] st);
        merge_byte = st[0] ? wd[7:0] : old;
    endfunction

    logic [7:0] scratch_q;
    logic [7:0] feature_q;
    logic [7:0] enhanced_q;
    logic [3:0] turn_q;
    logic [15:0] baud_div_q;
    logic [15:0] baud_cnt_q;
    logic baud_tick;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_ok;
    logic ef_en;
    tx_state_t state_q;
    logic [3:0] tick_q;
    logic [3:0] bits_q;
    logic pending_q;

    assign ef_en = enhanced_q[EF_ENABLE_BIT];

    // write path: address and data taken in either order, response after both
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_ok = aw_addr_q[7:2] <= OFS_STATUS[7:2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scratch_q <= RST_SCRATCH_STORE;
        end else if (wr_fire && aw_addr_q == OFS_SCRATCH_STORE) begin
            scratch_q <= merge_byte(scratch_q, w_data_q, w_strb_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            turn_q <= RST_TURNAROUND;
        end else if (wr_fire && aw_addr_q == OFS_MODEM_STATUS_LOCATION && ef_en
                     && w_strb_q[0]) begin
            turn_q <= w_data_q[TURN_LSB +: 4];
        end
    end

    // feature control holds enhanced bits; frozen while enable is clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feature_q <= RST_FEATURE_CONTROL;
        end else if (wr_fire && aw_addr_q == OFS_FEATURE_CONTROL && ef_en) begin
            feature_q <= merge_byte(feature_q, w_data_q, w_strb_q);
        end
    end

    // the enable bit itself is always writable, otherwise it could never be set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enhanced_q <= RST_ENHANCED_FEATURE;
        end else if (wr_fire && aw_addr_q == OFS_ENHANCED_FEATURE) begin
            enhanced_q <= merge_byte(enhanced_q, w_data_q, w_strb_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_div_q <= RST_BAUD_DIV;
        end else if (wr_fire && aw_addr_q == OFS_CONFIG) begin
            if (w_strb_q[0]) begin
                baud_div_q[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
                baud_div_q[15:8] <= w_data_q[15:8];
            end
        end
    end

    // read path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_MODEM_STATUS_LOCATION: s_axi_rdata <= 32'h0000_0000;
                OFS_SCRATCH_STORE: s_axi_rdata <= {24'h000000, scratch_q};
                OFS_FEATURE_CONTROL: s_axi_rdata <= {24'h000000, feature_q};
                OFS_ENHANCED_FEATURE: s_axi_rdata <= {24'h000000, enhanced_q};
                OFS_CONFIG: s_axi_rdata <= {16'h0000, baud_div_q};
                OFS_STATUS: s_axi_rdata <= {24'h000000, turn_q, state_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // baud tick from divider; a divider of zero behaves as one
    assign baud_tick = baud_cnt_q == 16'h0000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_cnt_q <= 16'h0000;
        end else if (baud_tick) begin
            baud_cnt_q <= (baud_div_q == 16'h0000) ? 16'h0000 : baud_div_q - 16'h0001;
        end else begin
            baud_cnt_q <= baud_cnt_q - 16'h0001;
        end
    end

    // a load that arrives mid-frame is remembered for the next frame; a load outside a
    // frame starts one at once, so remembering it as well would send a second frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_q <= 1'b0;
        end else if (tx_load_i && state_q == TX_SEND) begin
            pending_q <= 1'b1;
        end else if (state_q != TX_SEND) begin
            pending_q <= 1'b0;
        end
    end

    // transmit frame timing and turn-around delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= TX_IDLE;
            tick_q <= 4'h0;
            bits_q <= 4'h0;
        end else begin
            unique case (state_q)
                TX_IDLE, TX_TURN, TX_HOLD: begin
                    if (tx_load_i || pending_q || !tx_fifo_empty_i) begin
                        state_q <= TX_SEND;
                        tick_q <= TICKS_PER_BIT_M1;
                        bits_q <= FRAME_BITS;
                    end else if (state_q == TX_TURN && baud_tick) begin
                        if (tick_q != 4'h0) begin
                            tick_q <= tick_q - 4'h1;
                        end else if (bits_q <= 4'h1) begin
                            state_q <= TX_IDLE;
                        end else begin
                            tick_q <= TICKS_PER_BIT_M1;
                            bits_q <= bits_q - 4'h1;
                        end
                    end else if (state_q == TX_HOLD) begin
                        state_q <= TX_IDLE;
                    end
                end
                TX_SEND: begin
                    if (baud_tick) begin
                        if (tick_q != 4'h0) begin
                            tick_q <= tick_q - 4'h1;
                        end else if (bits_q == 4'h1) begin
                            // stop bit has left the shift register
                            tick_q <= TICKS_PER_BIT_M1;
                            bits_q <= turn_q;
                            state_q <= (turn_q == 4'h0) ? TX_HOLD : TX_TURN;
                        end else begin
                            tick_q <= TICKS_PER_BIT_M1;
                            bits_q <= bits_q - 4'h1;
                        end
                    end
                end
                default: state_q <= TX_IDLE;
            endcase
        end
    end

    // direction output: high from load through frame and turn-around
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rs485_dir_o <= 1'b0;
        end else if (!feature_q[FC_RS485_BIT]) begin
            rs485_dir_o <= 1'b0;
        end else if (tx_load_i || !tx_fifo_empty_i) begin
            rs485_dir_o <= 1'b1;
        end else begin
            rs485_dir_o <= state_q == TX_SEND || state_q == TX_TURN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_line_busy_o <= 1'b0;
            tx_int_o <= 1'b0;
        end else begin
            tx_line_busy_o <= state_q == TX_SEND;
            if (feature_q[FC_RS485_BIT]) begin
                tx_int_o <= tx_fifo_empty_i && !tx_load_i && state_q != TX_SEND;
            end else begin
                tx_int_o <= tx_fifo_empty_i && !tx_load_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir_rx_o <= 1'b0;
        end else begin
            ir_rx_o <= ir_rx_i ^ feature_q[FC_IR_INV_BIT];
        end
    end

    // flow control configuration decode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trigger_table_o <= 2'h0;
            flow_hysteresis_o <= 6'd0;
            flow_adjacent_level_o <= 1'b1;
        end else begin
            trigger_table_o <= feature_q[FC_TABLE_LSB +: 2];
            if (feature_q[FC_TABLE_LSB +: 2] == TABLE_D) begin
                flow_hysteresis_o <= hyst_chars(feature_q[3:0]);
                flow_adjacent_level_o <= feature_q[3:0] == 4'h0;
            end else begin
                flow_hysteresis_o <= 6'd0;
                flow_adjacent_level_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swfc_tx_mode_o <= SWFC_NONE;
            swfc_rx_mode_o <= SWFC_NONE;
            swfc_rx_either_o <= 1'b0;
            swfc_rx_sequence_o <= 1'b0;
        end else begin
            swfc_tx_mode_o <= enhanced_q[3:2];
            swfc_rx_mode_o <= enhanced_q[1:0];
            swfc_rx_either_o <= enhanced_q[1:0] == SWFC_BOTH
                && (enhanced_q[3:2] == SWFC_FIRST || enhanced_q[3:2] == SWFC_SECOND);
            swfc_rx_sequence_o <= enhanced_q[1:0] == SWFC_BOTH
                && (enhanced_q[3:2] == SWFC_BOTH || enhanced_q[3:2] == SWFC_NONE);
        end
    end
endmodule

//--- verif/uart_efc_assertions.sv
// checker for the enhanced feature control block, bound to its ports
module uart_efc_checker
    import uart_efc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tx_load_i,
    input wire logic tx_fifo_empty_i,
    input wire logic rs485_dir_o,
    input wire logic tx_line_busy_o,
    input wire logic tx_int_o,
    input wire logic [1:0] trigger_table_o,
    input wire logic [5:0] flow_hysteresis_o,
    input wire logic flow_adjacent_level_o,
    input wire logic [1:0] swfc_tx_mode_o,
    input wire logic [1:0] swfc_rx_mode_o,
    input wire logic swfc_rx_either_o,
    input wire logic swfc_rx_sequence_o
);
    logic [8:0] busy_len_q;
    // saturates so that a slow baud divider cannot wrap it into a false short frame
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_line_busy_o) begin
            busy_len_q <= 9'h000;
        end else if (busy_len_q != 9'h1FF) begin
            busy_len_q <= busy_len_q + 9'h001;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    dir_rise_a: assert property ($rose(rs485_dir_o) |->
        $past(tx_load_i || !tx_fifo_empty_i) ##1 tx_line_busy_o)
        else $error("direction rose without a load");
    dir_send_a: assert property (tx_line_busy_o && $past(rs485_dir_o) |-> rs485_dir_o)
        else $error("direction dropped while a frame shifts");
    dir_fall_a: assert property ($fell(rs485_dir_o) |-> !tx_line_busy_o)
        else $error("direction fell before the last stop bit");
    frame_len_a: assert property ($fell(tx_line_busy_o) |-> busy_len_q >= 9'h09F)
        else $error("frame shorter than ten bit periods");
    int_src_a: assert property (tx_line_busy_o && rs485_dir_o |-> !tx_int_o)
        else $error("tx interrupt while shift register busy");
    table_abc_a: assert property (trigger_table_o != TABLE_D |->
        flow_hysteresis_o == 6'h00 && flow_adjacent_level_o) else $error("hysteresis outside table d");
    hyst_zero_a: assert property (trigger_table_o == TABLE_D |->
        flow_adjacent_level_o == (flow_hysteresis_o == 6'h00)) else $error("adjacent level mismatch");
    rx_either_a: assert property (swfc_rx_either_o == (swfc_rx_mode_o == SWFC_BOTH
        && (swfc_tx_mode_o == SWFC_FIRST || swfc_tx_mode_o == SWFC_SECOND)))
        else $error("either-character match wrong");
    rx_seq_a: assert property (swfc_rx_sequence_o == (swfc_rx_mode_o == SWFC_BOTH
        && (swfc_tx_mode_o == SWFC_BOTH || swfc_tx_mode_o == SWFC_NONE)))
        else $error("sequence match wrong");
    cover property ($fell(rs485_dir_o));
    cover property (swfc_rx_either_o);
    cover property (swfc_rx_sequence_o);
    cover property (flow_hysteresis_o == 6'h34);
endmodule

bind uart_efc uart_efc_checker chk (.clk_i(clk_i), .rst_i(rst_i), .tx_load_i(tx_load_i),
    .tx_fifo_empty_i(tx_fifo_empty_i), .rs485_dir_o(rs485_dir_o), .tx_line_busy_o(tx_line_busy_o),
    .tx_int_o(tx_int_o), .trigger_table_o(trigger_table_o), .flow_hysteresis_o(flow_hysteresis_o),
    .flow_adjacent_level_o(flow_adjacent_level_o), .swfc_tx_mode_o(swfc_tx_mode_o),
    .swfc_rx_mode_o(swfc_rx_mode_o), .swfc_rx_either_o(swfc_rx_either_o),
    .swfc_rx_sequence_o(swfc_rx_sequence_o));

//--- verif/rs485_peer.sv
// remote peer behind the transceiver: sends pseudo-random ir receive data
module rs485_peer (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lfsr_q;
    // pseudo-random line so a stale or stuck sample cannot match by luck
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_q <= 8'h5A;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end
    end
    assign rx_o = lfsr_q[0];
endmodule

//--- verif/tb.sv
// self-checking bench for the enhanced feature control block
module tb
    import uart_efc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic ld = 1'b0, emp = 1'b1, awr, wrd, bv, arr, rv, ir_line, ir_out, dir, busy, tint;
    logic adj, eith, seqm;
    logic [1:0] bresp, rresp, tbl, txm, rxm;
    logic [5:0] hyst;
    logic [5:0] hv [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
        6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    int fails = 0, cmp_count = 0;
    logic [31:0] v;
    logic b;
    uart_efc uut (.clk_i(clk), .rst_i(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .tx_load_i(ld),
        .tx_fifo_empty_i(emp), .ir_rx_i(ir_line), .ir_rx_o(ir_out), .rs485_dir_o(dir),
        .tx_line_busy_o(busy), .tx_int_o(tint), .trigger_table_o(tbl),
        .flow_hysteresis_o(hyst), .flow_adjacent_level_o(adj), .swfc_tx_mode_o(txm),
        .swfc_rx_mode_o(rxm), .swfc_rx_either_o(eith), .swfc_rx_sequence_o(seqm));
    rs485_peer peer (.clk_i(clk), .rst_i(rst), .rx_o(ir_line));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk_pin(input string n, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // an error response carries no meaningful data, so only its code is compared
    task automatic chk_reg(input string n, input logic [33:0] e, input logic [33:0] g);
        chk_pin(n, e, (e[33:32] == RESP_SLVERR) ? {g[33:32], e[31:0]} : g);
    endtask
    always @(posedge clk) begin
        if (bv === 1'b1 && bry) chk_reg("bresp", exp_b.pop_front(), bresp);
        if (rv === 1'b1 && rry) chk_reg("rdata", exp_r.pop_front(), {rresp, rdat});
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        logic ap, wp;
        ap = 1'b1;
        wp = 1'b1;
        exp_b.push_back(er);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (ap || wp) begin
            @(posedge clk);
            if (ap && awr === 1'b1) awv <= 1'b0;
            if (ap && awr === 1'b1) ap = 1'b0;
            if (wp && wrd === 1'b1) wv <= 1'b0;
            if (wp && wrd === 1'b1) wp = 1'b0;
        end
        while (bv !== 1'b1) @(posedge clk);
        bry <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        exp_r.push_back({er, d});
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rry <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic load_byte;
        @(posedge clk);
        ld <= 1'b1;
        emp <= 1'b0;
        @(posedge clk);
        ld <= 1'b0;
        emp <= 1'b1;
        @(negedge clk);
    endtask
    task automatic frame(input int expc);
        int n;
        n = 0;
        load_byte;
        chk_pin("dir_raised", 1, dir);
        chk_pin("int_sending", 0, tint);
        while (dir === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk_pin("dir_span", 1, n >= expc && n <= expc + 4);
        chk_pin("busy_done", 0, busy);
        chk_pin("int_idle", 1, tint);
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'hA375));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_SCRATCH_STORE, 32'h000000FF);
        rd(OFS_ENHANCED_FEATURE, 32'h0);
        rd(OFS_STATUS, 32'h1);
        rd(OFS_MODEM_STATUS_LOCATION, 32'h0);
        chk_pin("adjacent_rst", 1, adj);
        chk_pin("swfc_rst", 0, {txm, rxm});
        $display("test reset done");
        v = $urandom;
        wr(OFS_SCRATCH_STORE, v);
        wr(8'h18, 32'h0, RESP_SLVERR);
        rd(8'h1C, 32'h0, RESP_SLVERR);
        rd(OFS_SCRATCH_STORE, {24'h0, v[7:0]});
        wr(OFS_FEATURE_CONTROL, 32'hC5);
        rd(OFS_FEATURE_CONTROL, 32'h0);
        wr(OFS_MODEM_STATUS_LOCATION, 32'hF0);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_ENHANCED_FEATURE, 32'h10);
        wr(OFS_FEATURE_CONTROL, 32'hC5);
        wr(OFS_ENHANCED_FEATURE, 32'h0);
        wr(OFS_FEATURE_CONTROL, 32'h00);
        rd(OFS_FEATURE_CONTROL, 32'hC5);
        $display("test gating done");
        wr(OFS_ENHANCED_FEATURE, 32'h10);
        for (int c = 0; c < 16; c++) begin
            wr(OFS_FEATURE_CONTROL, {24'h0, 4'hC, 4'(c)});
            settle;
            chk_pin("table", TABLE_D, tbl);
            chk_pin("hysteresis", hv[c], hyst);
            chk_pin("adjacent", c == 0, adj);
        end
        for (int t = 0; t < 3; t++) begin
            wr(OFS_FEATURE_CONTROL, {24'h0, 2'(t), 6'h0F});
            settle;
            chk_pin("table", t, tbl);
            chk_pin("hysteresis", 0, hyst);
            chk_pin("adjacent", 1, adj);
        end
        $display("test hysteresis done");
        for (int p = 0; p < 2; p++) begin
            wr(OFS_FEATURE_CONTROL, {27'h0, 1'(p), 4'h0});
            repeat (8) begin
                @(negedge clk);
                b = ir_line;
                @(negedge clk);
                chk_pin("ir_rx", b ^ 1'(p), ir_out);
            end
        end
        $display("test ir done");
        for (int m = 0; m < 16; m++) begin
            wr(OFS_ENHANCED_FEATURE, 32'h10);
            wr(OFS_ENHANCED_FEATURE, {27'h0, 1'b1, 4'(m)});
            settle;
            chk_pin("tx_mode", m / 4, txm);
            chk_pin("rx_mode", m % 4, rxm);
            chk_pin("either", m == 7 || m == 11, eith);
            chk_pin("sequence", m == 3 || m == 15, seqm);
            rd(OFS_ENHANCED_FEATURE, {27'h0, 1'b1, 4'(m)});
        end
        $display("test swfc done");
        wr(OFS_ENHANCED_FEATURE, 32'h10);
        wr(OFS_FEATURE_CONTROL, 32'h20);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_MODEM_STATUS_LOCATION, {24'h0, 4'(k * 15), 4'h0});
            rd(OFS_STATUS, {24'h0, 4'(k * 15), 4'h1});
            frame(160 + 16 * k * 15);
        end
        v = 1 + $urandom % 14;
        wr(OFS_CONFIG, 32'h2);
        wr(OFS_MODEM_STATUS_LOCATION, {24'h0, v[3:0], 4'h0});
        frame((160 + 16 * v) * 2);
        wr(OFS_CONFIG, 32'h1);
        wr(OFS_FEATURE_CONTROL, 32'h00);
        load_byte;
        settle;
        chk_pin("busy_plain", 1, busy);
        chk_pin("int_plain", 1, tint);
        chk_pin("dir_plain", 0, dir);
        repeat (200) @(posedge clk);
        $display("test rs485 done");
        end_of_test;
    end
endmodule
